//--- design/dsrc_pkg.sv
`default_nettype none
package dsrc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_MTC   = 5'h00;
    localparam logic [4:0] OFS_A2DC  = 5'h04;
    localparam logic [4:0] OFS_CST   = 5'h08;
    localparam logic [4:0] OFS_RTCS  = 5'h0c;
    localparam logic [4:0] OFS_RCNT  = 5'h10;
    localparam logic [4:0] OFS_RCON  = 5'h14;
    localparam logic [4:0] OFS_SDMB  = 5'h18;
    localparam logic [4:0] OFS_STAT  = 5'h1c;
    // ------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MTC_MASK  = 16'hff7f;
    localparam logic [15:0] A2DC_MASK = 16'hf35e;
    localparam logic [15:0] CST_MASK  = 16'h00ff;
    localparam logic [15:0] REG_RST   = 16'h0000;
    localparam logic [7:0]  WR_KEY    = 8'ha5;
    localparam logic [11:0] SDM_MAX   = 12'hffc;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TPC_LSB  = 14;
    localparam int RCD_LSB  = 12;
    localparam int TRAS_LSB = 8;
    localparam int BE_BIT   = 6;
    localparam int SZ_BIT   = 5;
    localparam int AMX_LSB  = 3;
    localparam int REFRESH_ENABLE_BIT = 2;
    localparam int RMOD_BIT = 1;
    localparam int EDO_BIT  = 0;
    localparam int CMF_BIT  = 7;
    localparam int CKS_LSB  = 3;
    // ------------------------------------------------------------
    // cycle figures
    // ------------------------------------------------------------
    localparam logic [3:0] TPC_BASE  = 4'h1;
    localparam logic [3:0] TPCS_BASE = 4'h2;
    localparam logic [3:0] TPCS_STEP = 4'h3;
    localparam logic [3:0] RCD_BASE  = 4'h1;
    localparam logic [3:0] TRAS_BASE = 4'h2;
    localparam logic [3:0] COL_BASE  = 4'h8;
    localparam logic [4:0] SDR_SHIFT = 5'h08;
    localparam logic [4:0] A2_WIDTH  = 5'h10;
    typedef enum logic [3:0] {
        RS_IDLE = 4'b0001,
        RS_CBR  = 4'b0010,
        RS_SELF = 4'b0100,
        RS_PRE  = 4'b1000
    } dsrc_state_t;
endpackage
`default_nettype wire

//--- design/dsrc_prescale.sv
`default_nettype none
// ------------------------------------------------------------
// refresh timer prescaler: one tick per selected bus clock ratio
// ------------------------------------------------------------
module dsrc_prescale (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    logic [11:0] cnt_r;
    logic        hit;
    assign hit = (sel_i == 3'h1) ? (cnt_r[1:0] == 2'h3) :
                 (sel_i == 3'h2) ? (cnt_r[3:0] == 4'hf) :
                 (sel_i == 3'h3) ? (cnt_r[5:0] == 6'h3f) :
                 (sel_i == 3'h4) ? (cnt_r[7:0] == 8'hff) :
                 (sel_i == 3'h5) ? (cnt_r[9:0] == 10'h3ff) :
                 (sel_i == 3'h6) ? (cnt_r[10:0] == 11'h7ff) :
                 (sel_i == 3'h7) ? (cnt_r == 12'hfff) : 1'b0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 12'h000;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + 12'h001;
            tick_o <= hit;
        end
    end
endmodule // dsrc_prescale
`default_nettype wire

//--- design/dsrc_delay.sv
`default_nettype none
// ------------------------------------------------------------
// down counter: done after the loaded number of cycles
// ------------------------------------------------------------
module dsrc_delay (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       load_i,
    input  wire logic [3:0] cycles_i,
    output logic            busy_o
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
        end else if (load_i) begin
            cnt_r <= cycles_i;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign busy_o = (cnt_r != 4'h0);
endmodule // dsrc_delay
`default_nettype wire

//--- design/dsrc_ctrl.sv
`default_nettype none
module dsrc_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [12:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             err_o,
    // external bus cycle in progress and its abort
    input  wire logic        bus_busy_i,
    output logic             bus_abort_o,
    // memory side strobes
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             self_refresh_o,
    output logic             sdram_mode_wr_o,
    output logic [9:0]       sdram_mode_val_o,
    // decoded timing for the access sequencer
    output logic [3:0]       col_width_o,
    output logic [4:0]       sdram_row_shift_o,
    output logic [3:0]       precharge_cyc_o,
    output logic [3:0]       ras_cas_cyc_o,
    output logic             page_mode_o,
    output logic [4:0]       area2_width_o,
    output logic             edo_rise_sample_o,
    output logic             edo_ras_half_o,
    output logic [7:0]       card_timing_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] mtc_r;
    logic [15:0] a2dc_r;
    logic [15:0] cst_r;
    logic [7:0]  rtcs_r;
    logic [7:0]  rcnt_r;
    logic [7:0]  rcon_r;
    logic        cmf_wr0_r;
    logic        ack_r;
    logic        err_r;
    logic [31:0] dat_r;
    dsrc_pkg::dsrc_state_t state_r;
    dsrc_pkg::dsrc_state_t state_nxt;
    logic        was_self_r;
    logic        pend_r;
    logic        ras_n_r;
    logic        cas_n_r;
    logic        abort_r;
    logic        mode_wr_r;
    logic [9:0]  mode_val_r;
    logic [13:0] timing_r;
    logic [4:0]  shift_r;
    logic        self_r;
    logic        bb_meta_r;
    logic        bb_sync_r;
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        req;
    logic        wr;
    logic        rd;
    logic        word_lo;
    logic        key_ok;
    logic        in_map;
    logic        is_mode;
    logic [4:0]  reg_ofs;
    logic [11:0] mode_x;
    assign req     = cyc_i & stb_i & ~ack_r & ~err_r;
    assign is_mode = adr_i[12];
    assign mode_x  = adr_i[11:0];
    assign reg_ofs = adr_i[4:0];
    assign word_lo = (sel_i[1:0] == 2'h3);
    assign key_ok  = word_lo & (dat_i[15:8] == dsrc_pkg::WR_KEY);
    assign in_map  = is_mode ? (we_i & (mode_x <= dsrc_pkg::SDM_MAX))
                   : (adr_i[11:5] == 7'h00) && (reg_ofs[1:0] == 2'h0);
    assign wr      = req & we_i & in_map;
    assign rd      = req & ~we_i & in_map;
    logic wr_mtc;
    logic wr_a2dc;
    logic wr_cst;
    logic wr_rtcs;
    logic wr_rcnt;
    logic wr_rcon;
    assign wr_mtc  = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_MTC) & word_lo;
    assign wr_a2dc = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_A2DC) & word_lo;
    assign wr_cst  = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_CST) & word_lo;
    assign wr_rtcs = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_RTCS) & key_ok;
    assign wr_rcnt = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_RCNT) & key_ok;
    assign wr_rcon = wr & ~is_mode & (reg_ofs == dsrc_pkg::OFS_RCON) & key_ok;
    logic [15:0] rd_word;
    assign rd_word = (reg_ofs == dsrc_pkg::OFS_MTC)  ? mtc_r :
                     (reg_ofs == dsrc_pkg::OFS_A2DC) ? a2dc_r :
                     (reg_ofs == dsrc_pkg::OFS_CST)  ? cst_r :
                     (reg_ofs == dsrc_pkg::OFS_RTCS) ? {8'h00, rtcs_r} :
                     (reg_ofs == dsrc_pkg::OFS_RCNT) ? {8'h00, rcnt_r} :
                     (reg_ofs == dsrc_pkg::OFS_RCON) ? {8'h00, rcon_r} :
                     (reg_ofs == dsrc_pkg::OFS_STAT) ?
                         {12'h000, was_self_r, pend_r, state_r[2], state_r[1]} :
                     16'h0000;
    // ------------------------------------------------------------
    // refresh timer
    // ------------------------------------------------------------
    logic tick;
    logic match;
    logic refresh_enable_en;
    logic self_mode;
    logic cbr_done;
    dsrc_prescale u_prescale (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .sel_i  (rtcs_r[dsrc_pkg::CKS_LSB +: 3]),
        .tick_o (tick)
    );
    assign match     = tick & (rcnt_r == rcon_r);
    assign refresh_enable_en   = mtc_r[dsrc_pkg::REFRESH_ENABLE_BIT] | a2dc_r[dsrc_pkg::REFRESH_ENABLE_BIT];
    assign self_mode = mtc_r[dsrc_pkg::RMOD_BIT] | a2dc_r[dsrc_pkg::RMOD_BIT];
    // ------------------------------------------------------------
    // timing decode
    // ------------------------------------------------------------
    logic [1:0] tpc;
    logic [1:0] tras;
    logic [3:0] pre_cyc;
    logic [3:0] tras_cyc;
    assign tpc      = a2dc_r[dsrc_pkg::TPC_LSB +: 2];
    assign tras     = a2dc_r[dsrc_pkg::TRAS_LSB +: 2];
    // after self-refresh the precharge step widens to two cycles plus three per tpc unit
    assign pre_cyc  = was_self_r ?
                      dsrc_pkg::TPCS_BASE + dsrc_pkg::TPCS_STEP * {2'b00, tpc} :
                      dsrc_pkg::TPC_BASE + {2'b00, tpc};
    assign tras_cyc = dsrc_pkg::TRAS_BASE + {2'b00, tras};
    logic ras_busy;
    logic pre_busy;
    logic load_ras;
    logic load_pre;
    // the bus cycle is cut first; the refresh starts once the bus has let go
    assign load_ras = (state_r == dsrc_pkg::RS_IDLE) & pend_r & ~self_mode & refresh_enable_en &
                      ~bb_sync_r;
    assign load_pre = ((state_r == dsrc_pkg::RS_CBR) & ~ras_busy) |
                      ((state_r == dsrc_pkg::RS_SELF) & ~(refresh_enable_en & self_mode));
    dsrc_delay u_ras (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (load_ras),
        .cycles_i (tras_cyc),
        .busy_o   (ras_busy)
    );
    dsrc_delay u_pre (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (load_pre),
        .cycles_i (pre_cyc),
        .busy_o   (pre_busy)
    );
    assign cbr_done = (state_r == dsrc_pkg::RS_CBR) & ~ras_busy;
    // ------------------------------------------------------------
    // refresh sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dsrc_pkg::RS_IDLE: begin
                if (refresh_enable_en & self_mode & ~bb_sync_r) begin
                    state_nxt = dsrc_pkg::RS_SELF;
                end else if (load_ras) begin
                    state_nxt = dsrc_pkg::RS_CBR;
                end
            end
            dsrc_pkg::RS_CBR: begin
                if (~ras_busy) begin
                    state_nxt = dsrc_pkg::RS_PRE;
                end
            end
            dsrc_pkg::RS_SELF: begin
                if (~(refresh_enable_en & self_mode)) begin
                    state_nxt = dsrc_pkg::RS_PRE;
                end
            end
            dsrc_pkg::RS_PRE: begin
                if (~pre_busy & ~load_pre) begin
                    state_nxt = dsrc_pkg::RS_IDLE;
                end
            end
            default: state_nxt = dsrc_pkg::RS_IDLE;
        endcase
    end
    // ------------------------------------------------------------
    // bus slave and registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & in_map;
            err_r <= req & ~in_map;
            dat_r <= rd ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end
    // power-on reset is the only reset seen here; these hold otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mtc_r  <= dsrc_pkg::REG_RST;
            a2dc_r <= dsrc_pkg::REG_RST;
            cst_r  <= dsrc_pkg::REG_RST;
            rcon_r <= 8'h00;
        end else begin
            if (wr_mtc) mtc_r <= dat_i[15:0] & dsrc_pkg::MTC_MASK;
            if (wr_a2dc) a2dc_r <= dat_i[15:0] & dsrc_pkg::A2DC_MASK;
            if (wr_cst) cst_r <= dat_i[15:0] & dsrc_pkg::CST_MASK;
            if (wr_rcon) rcon_r <= dat_i[7:0];
        end
    end
    // compare flag: match wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtcs_r    <= 8'h00;
            cmf_wr0_r <= 1'b0;
        end else begin
            if (wr_rtcs) begin
                rtcs_r[6:0] <= dat_i[6:0];
            end
            if (match) begin
                rtcs_r[dsrc_pkg::CMF_BIT] <= 1'b1;
            end else if (cbr_done & cmf_wr0_r) begin
                rtcs_r[dsrc_pkg::CMF_BIT] <= 1'b0;
            end
            // a written 0 stays armed across matches until a cbr refresh ends
            if (wr_rtcs & ~dat_i[dsrc_pkg::CMF_BIT]) begin
                cmf_wr0_r <= 1'b1;
            end else if (cbr_done) begin
                cmf_wr0_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rcnt_r <= 8'h00;
        end else if (match) begin
            rcnt_r <= 8'h00;
        end else if (wr_rcnt) begin
            rcnt_r <= dat_i[7:0];
        end else if (tick) begin
            rcnt_r <= rcnt_r + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // refresh request and strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bb_meta_r <= 1'b0;
            bb_sync_r <= 1'b0;
            state_r   <= dsrc_pkg::RS_IDLE;
            pend_r    <= 1'b0;
            was_self_r <= 1'b0;
            abort_r   <= 1'b0;
        end else begin
            bb_meta_r <= bus_busy_i;
            bb_sync_r <= bb_meta_r;
            state_r   <= state_nxt;
            if (~refresh_enable_en | self_mode | (state_r == dsrc_pkg::RS_SELF)) begin
                pend_r <= 1'b0;
            end else if (match) begin
                pend_r <= 1'b1;
            end else if (load_ras) begin
                pend_r <= 1'b0;
            end
            abort_r <= pend_r & bb_sync_r & ~self_mode;
            if (state_r == dsrc_pkg::RS_SELF) begin
                was_self_r <= 1'b1;
            end else if (state_r == dsrc_pkg::RS_IDLE) begin
                was_self_r <= 1'b0;
            end
        end
    end
    // cbr: cas falls one cycle before ras; self-refresh keeps both low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ras_n_r <= 1'b1;
            cas_n_r <= 1'b1;
            self_r  <= 1'b0;
        end else begin
            self_r  <= (state_r == dsrc_pkg::RS_SELF);
            ras_n_r <= ~(((state_r == dsrc_pkg::RS_CBR) & ras_busy) |
                         (state_r == dsrc_pkg::RS_SELF));
            cas_n_r <= ~((state_r == dsrc_pkg::RS_CBR) | load_ras |
                         (state_r == dsrc_pkg::RS_SELF));
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_wr_r  <= 1'b0;
            mode_val_r <= 10'h000;
        end else begin
            mode_wr_r <= wr & is_mode;
            if (wr & is_mode) mode_val_r <= mode_x[11:2];
        end
    end
    // ------------------------------------------------------------
    // decoded timing outputs
    // ------------------------------------------------------------
    logic [1:0] amx;
    logic       edo;
    assign amx = a2dc_r[dsrc_pkg::AMX_LSB +: 2] | mtc_r[dsrc_pkg::AMX_LSB +: 2];
    assign edo = mtc_r[dsrc_pkg::EDO_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timing_r <= 14'h0000;
            shift_r  <= dsrc_pkg::SDR_SHIFT;
        end else begin
            timing_r[3:0]  <= dsrc_pkg::COL_BASE + {2'b00, amx};
            timing_r[7:4]  <= dsrc_pkg::RCD_BASE +
                              {2'b00, a2dc_r[dsrc_pkg::RCD_LSB +: 2]};
            timing_r[11:8] <= pre_cyc;
            timing_r[12]   <= a2dc_r[dsrc_pkg::BE_BIT];
            timing_r[13]   <= edo;
            shift_r        <= dsrc_pkg::SDR_SHIFT + {3'b000, amx};
        end
    end
    assign dat_o             = dat_r;
    assign ack_o             = ack_r;
    assign err_o             = err_r;
    assign bus_abort_o       = abort_r;
    assign ras_n_o           = ras_n_r;
    assign cas_n_o           = cas_n_r;
    assign self_refresh_o    = self_r;
    assign sdram_mode_wr_o   = mode_wr_r;
    assign sdram_mode_val_o  = mode_val_r;
    assign col_width_o       = timing_r[3:0];
    assign sdram_row_shift_o = shift_r;
    assign precharge_cyc_o   = timing_r[11:8];
    assign ras_cas_cyc_o     = timing_r[7:4];
    assign page_mode_o       = timing_r[12];
    assign area2_width_o     = dsrc_pkg::A2_WIDTH;
    assign edo_rise_sample_o = timing_r[13];
    assign edo_ras_half_o    = timing_r[13];
    assign card_timing_o     = cst_r[7:0];
endmodule // dsrc_ctrl
`default_nettype wire

//--- tb/dsrc_mem_model.sv
`default_nettype none
// ----
// far-side memory: runs bus cycles and measures cbr strobes
// ----
module dsrc_mem_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ras_n_i,
    input  wire logic       cas_n_i,
    input  wire logic       abort_i,
    input  wire logic       start_i,
    input  wire logic [7:0] len_i,
    output logic            busy_o,
    output logic            cut_o,
    output logic [3:0]      ras_len_o,
    output logic [7:0]      cbr_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_r;
    logic [3:0] run_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            cut_o <= 1'b0;
            left_r <= 8'h00;
            run_r <= 4'h0;
            ras_len_o <= 4'h0;
            cbr_cnt_o <= 8'h00;
        end else begin
            if (start_i) begin
                busy_o <= 1'b1;
                cut_o <= 1'b0;
                left_r <= len_i;
            end else if (busy_o && abort_i) begin
                busy_o <= 1'b0;
                cut_o <= 1'b1;
            end else if (busy_o) begin
                left_r <= left_r - 8'h01;
                busy_o <= (left_r != 8'h01);
            end
            // count only while both strobes are low, as in a cbr cycle
            run_r <= (!ras_n_i && !cas_n_i) ? run_r + 4'h1 : 4'h0;
            if (ras_n_i && run_r != 4'h0) begin
                ras_len_o <= run_r;
                cbr_cnt_o <= cbr_cnt_o + 8'h01;
            end
        end
    end
endmodule // dsrc_mem_model
`default_nettype wire

//--- tb/dsrc_ctrl_assertions.sv
`default_nettype none
// ----
// port checker
// ----
module dsrc_ctrl_chk (
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire logic [12:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o, err_o, bus_abort_o, ras_n_o, cas_n_o,
    input wire logic self_refresh_o, sdram_mode_wr_o, page_mode_o,
    input wire logic edo_rise_sample_o, edo_ras_half_o,
    input wire logic [9:0] sdram_mode_val_o,
    input wire logic [3:0] col_width_o, ras_cas_cyc_o,
    input wire logic [4:0] sdram_row_shift_o, area2_width_o,
    input wire logic [7:0] card_timing_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [9:0] madr_r;
    always_ff @(posedge clk_i) begin
        if (cyc_i && stb_i && adr_i[12]) madr_r <= adr_i[11:2];
    end
    sequence wr_s(logic [4:0] a);
        ack_o && we_i && sel_i[1:0] == 2'b11 && adr_i == {8'h00, a};
    endsequence
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    col_width_a: assert property (wr_s(dsrc_pkg::OFS_MTC) |-> ##2
        col_width_o == 4'h8 + $past(dat_i[4:3], 2)) else $error("column width");
    row_shift_a: assert property (wr_s(dsrc_pkg::OFS_MTC) |-> ##2
        sdram_row_shift_o == 5'h08 + $past(dat_i[4:3], 2)) else $error("row shift");
    edo_pair_a: assert property (wr_s(dsrc_pkg::OFS_MTC) |-> ##2
        edo_rise_sample_o == $past(dat_i[0], 2) && edo_ras_half_o == edo_rise_sample_o)
        else $error("edo outputs");
    a2_width_a: assert property (area2_width_o == 5'h10) else $error("width");
    page_mode_a: assert property (wr_s(dsrc_pkg::OFS_A2DC) |-> ##2
        page_mode_o == $past(dat_i[6], 2)) else $error("page mode");
    ras_cas_a: assert property (wr_s(dsrc_pkg::OFS_A2DC) |-> ##2
        ras_cas_cyc_o == 4'h1 + $past(dat_i[13:12], 2)) else $error("ras cas");
    card_time_a: assert property (wr_s(dsrc_pkg::OFS_CST) |-> ##2
        card_timing_o == $past(dat_i[7:0], 2)) else $error("card timing");
    mode_val_a: assert property (sdram_mode_wr_o |-> sdram_mode_val_o == madr_r)
        else $error("mode value");
    self_strobe_a: assert property (self_refresh_o |-> !ras_n_o && !cas_n_o)
        else $error("self strobes");
    self_quiet_a: assert property (self_refresh_o |-> !bus_abort_o)
        else $error("abort in self refresh");
    err_high_a: assert property (cyc_i && stb_i && !we_i && adr_i[12] && !ack_o && !err_o
        |=> err_o) else $error("no error");
endmodule // dsrc_ctrl_chk
bind dsrc_ctrl dsrc_ctrl_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .ack_o, .err_o, .bus_abort_o, .ras_n_o, .cas_n_o, .self_refresh_o,
    .sdram_mode_wr_o, .page_mode_o, .edo_rise_sample_o, .edo_ras_half_o,
    .sdram_mode_val_o, .col_width_o, .ras_cas_cyc_o, .sdram_row_shift_o,
    .area2_width_o, .card_timing_o);
`default_nettype wire

//--- tb/dsrc_ctrl_tb_top.sv
`default_nettype none
// ----
// register-level bench
// ----
module dsrc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, bus_busy_i;
    logic [12:0] adr_i = 0;
    logic [3:0] sel_i = 0, col_width_o, precharge_cyc_o, ras_cas_cyc_o, ras_len;
    logic [31:0] dat_i = 0, dat_o, q;
    logic ack_o, err_o, bus_abort_o, ras_n_o, cas_n_o, self_refresh_o, e, m_cut;
    logic sdram_mode_wr_o, page_mode_o, edo_rise_sample_o, edo_ras_half_o, m_start = 0;
    logic [9:0] sdram_mode_val_o;
    logic [4:0] sdram_row_shift_o, area2_width_o;
    logic [7:0] card_timing_o, cbr_cnt, m_len = 0, n0;
    int n_mismatch = 0, samples_checked = 0, n_cyc = 0;
    always #10 clk_i = ~clk_i;
    dsrc_ctrl uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .err_o, .bus_busy_i, .bus_abort_o, .ras_n_o, .cas_n_o, .self_refresh_o,
        .sdram_mode_wr_o, .sdram_mode_val_o, .col_width_o, .sdram_row_shift_o,
        .precharge_cyc_o, .ras_cas_cyc_o, .page_mode_o, .area2_width_o,
        .edo_rise_sample_o, .edo_ras_half_o, .card_timing_o);
    dsrc_mem_model mem (.clk_i, .rst_i, .ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
        .abort_i(bus_abort_o), .start_i(m_start), .len_i(m_len), .busy_o(bus_busy_i),
        .cut_o(m_cut), .ras_len_o(ras_len), .cbr_cnt_o(cbr_cnt));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, input logic [12:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
        dat_i <= {16'h0000, d}; sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (!(ack_o || err_o));
        q = dat_o; e = err_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, {8'h00, a}, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x);
        bus(1'b0, {8'h00, a}, 16'h0000);
        chk(q, x);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // cut a hang short well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        n_cyc++;
        if (n_cyc == 20000) begin n_mismatch++; wrap_up(); end
    end
    initial begin
        tick(5);
        rst_i <= 1'b0;
        rd(dsrc_pkg::OFS_MTC, 0);
        rd(dsrc_pkg::OFS_A2DC, 0);
        rd(dsrc_pkg::OFS_CST, 0);
        rd(dsrc_pkg::OFS_RTCS, 0);
        chk(area2_width_o, 32'h10);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, i ? 13'h1ffc : 13'h18c0, 16'h5a5a);
            for (int j = 0; j < 5 && sdram_mode_wr_o !== 1'b1; j++) tick(1);
            chk({sdram_mode_wr_o, sdram_mode_val_o}, i ? 32'h7ff : 32'h630);
            tick(2);
        end
        bus(1'b0, 13'h1000, 16'h0000);
        chk(e, 1);
        bus(1'b0, 13'h0002, 16'h0000);
        chk(e, 1);
        $display("test reset, mode and errors done");
        for (int k = 0; k < 4; k++) begin
            wr(dsrc_pkg::OFS_MTC, 16'(32'h80 | (k << 3) | (k & 1)));
            tick(2);
            rd(dsrc_pkg::OFS_MTC, (k << 3) | (k & 1));
            chk(col_width_o, 8 + k);
            chk(sdram_row_shift_o, 8 + k);
            chk(edo_rise_sample_o, k & 1);
            chk(edo_ras_half_o, k & 1);
        end
        wr(dsrc_pkg::OFS_MTC, 16'h0200);
        wr(dsrc_pkg::OFS_A2DC, 16'hfff8);
        tick(2);
        rd(dsrc_pkg::OFS_A2DC, 32'hf358);
        chk(ras_cas_cyc_o, 4);
        chk(precharge_cyc_o, 4);
        chk(page_mode_o, 1);
        wr(dsrc_pkg::OFS_CST, 16'hffa5);
        tick(2);
        rd(dsrc_pkg::OFS_CST, 32'ha5);
        chk(card_timing_o, 32'ha5);
        $display("test timing fields done");
        wr(dsrc_pkg::OFS_RCON, 16'ha503);
        wr(dsrc_pkg::OFS_RTCS, 16'h0008);
        rd(dsrc_pkg::OFS_RTCS, 0);
        wr(dsrc_pkg::OFS_RTCS, 16'ha508);
        tick(100);
        rd(dsrc_pkg::OFS_RTCS, 32'h88);
        chk(cbr_cnt, 0);
        wr(dsrc_pkg::OFS_A2DC, 16'h0204);
        for (int j = 0; j < 300 && cbr_cnt == 0; j++) tick(1);
        chk(cbr_cnt != 0, 1);
        chk(ras_len, 4);
        wr(dsrc_pkg::OFS_RTCS, 16'ha508);
        tick(3);
        n0 = cbr_cnt;
        for (int j = 0; j < 100 && cbr_cnt == n0; j++) tick(1);
        rd(dsrc_pkg::OFS_RTCS, 32'h08);
        m_start <= 1'b1;
        m_len <= 8'd200;
        tick(1);
        m_start <= 1'b0;
        tick(1);
        for (int j = 0; j < 300 && bus_busy_i; j++) tick(1);
        chk(m_cut, 1);
        $display("test periodic refresh done");
        wr(dsrc_pkg::OFS_A2DC, 16'h0200);
        m_start <= 1'b1;
        m_len <= 8'd40;
        tick(1);
        m_start <= 1'b0;
        wr(dsrc_pkg::OFS_A2DC, 16'h0206);
        tick(10);
        chk(self_refresh_o, 0);
        for (int j = 0; j < 100 && self_refresh_o !== 1'b1; j++) tick(1);
        chk(self_refresh_o, 1);
        chk(bus_busy_i, 0);
        n0 = cbr_cnt;
        tick(100);
        chk(cbr_cnt, n0);
        chk(precharge_cyc_o, 2);
        wr(dsrc_pkg::OFS_A2DC, 16'h0200);
        tick(3);
        chk(self_refresh_o, 0);
        $display("test self refresh done");
        wrap_up();
    end
endmodule // dsrc_ctrl_tb_top
`default_nettype wire
